// ---- hw/apls_axis.sv ----
// Purpose: One axis of pulse output, end-limit and slow-down handling with filtered inputs
// Assumes: Machine inputs synchronous to sys_clk_in; start speed divisor >= top speed divisor
// Notes:   Speed is a divisor of clocks per output unit; one pulse period is rmg+1 units
//
// The placing of the registers and strobed register access were decided locally.

`timescale 1ns/1ps
`default_nettype none

module apls_axis #(
  parameter int SPD_W             = 16,
  parameter int CNT_W             = 24,
  parameter int DIR_WAIT_LONG_CYC = apls_pkg::DIR_WAIT_LONG_CYC_DEF,
  parameter int FILT_25U_CYC      = apls_pkg::FILT_25U_CYC_DEF,
  parameter int FILT_200U_CYC     = apls_pkg::FILT_200U_CYC_DEF,
  parameter int FILT_1M6_CYC      = apls_pkg::FILT_1M6_CYC_DEF
) (
  // Clock and reset
  input  wire logic                       sys_clk_in,
  input  wire logic                       rstn_in,
  // Register port
  input  wire apls_pkg::apls_bus_req_type bus_in,
  output logic [apls_pkg::DATA_W-1:0]     rdata_out,
  // Driver pins
  output logic                            pulse_output_pin_out,
  output logic                            direction_output_pin_out,
  // Machine switches
  input  wire logic                       positive_limit_input_in,
  input  wire logic                       negative_limit_input_in,
  input  wire logic                       slowdown_switch_input_in,
  input  wire logic                       origin_switch_input_in,
  input  wire logic                       limit_logic_select_in,
  // Axis status
  output logic                            busy_out,
  output logic                            done_out
);
  import apls_pkg::*;

  typedef struct packed {
    apls_state_type                 st;
    logic [DATA_W-1:0]              env1;
    logic [DATA_W-1:0]              prmd;
    logic [SPD_W-1:0]               speed_multiplier_setting;
    logic [SPD_W-1:0]               fl_div;
    logic [SPD_W-1:0]               fh_div;
    logic [SPD_W-1:0]               cur_div;
    logic [SPD_W-1:0]               unit_cnt;
    logic [SPD_W-1:0]               phase;
    logic [CNT_W-1:0]               pcount;
    logic [CNT_W-1:0]               remain;
    logic                           ramp;
    logic                           endless;
    logic                           final_p;
    logic                           imm_stop;
    logic                           dec_stop;
    logic                           dir_neg;
    logic                           act;
    logic [1:0]                     quad;
    logic [WAIT_W-1:0]              wait_cnt;
    logic [N_FILT-1:0]              filt;
    logic [N_FILT-1:0][FCNT_W-1:0]  fcnt;
    logic                           sd_latch;
    logic [DATA_W-1:0]              cause;
    logic                           busy;
    logic                           done;
    logic                           out_pin;
    logic                           dir_pin;
    logic [DATA_W-1:0]              rdata;
  } apls_axis_state_type;

  localparam apls_axis_state_type STATE_RST = '{st: ST_IDLE, env1: ENV1_RST, prmd: PRMD_RST,
                                                out_pin: 1'b1, dir_pin: 1'b1, default: '0};

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic [1:0]          rst_sync_q;
  logic                rst_n;
  apls_axis_state_type r_q;
  apls_axis_state_type r_d;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Decoded conditions
  logic [N_FILT-1:0] raw;
  logic [FCNT_W-1:0] filt_lim;
  logic              pel_on;
  logic              mel_on;
  logic              sd_on;
  logic              org_on;
  logic              sd_slow;
  logic              sd_stop;
  logic [SPD_W:0]    period_w;
  logic [SPD_W-1:0]  on_units;
  logic [SPD_W-1:0]  phase_inc;
  logic              tick;
  logic              per_end;
  logic              act_end;
  logic [2:0]        pmd;
  logic              wr_cmd;
  logic [7:0]        cmd;
  logic              start_cmd;
  logic              start_neg;

  assign raw = {origin_switch_input_in, slowdown_switch_input_in,
                negative_limit_input_in, positive_limit_input_in};

  always_comb begin
    if (!r_q.env1[ENV_FLTR]) begin
      filt_lim = FCNT_W'(FILT_OFF_CYC);
    end else begin
      unique case (r_q.env1[ENV_FTM_LSB +: 2])
        2'h0:    filt_lim = FCNT_W'(FILT_3U2_CYC);
        2'h1:    filt_lim = FCNT_W'(FILT_25U_CYC);
        2'h2:    filt_lim = FCNT_W'(FILT_200U_CYC);
        default: filt_lim = FCNT_W'(FILT_1M6_CYC);
      endcase
    end
  end

  // Limit polarity pin: low means active-high switches
  assign pel_on  = r_q.filt[FI_PEL] ^ limit_logic_select_in;
  assign mel_on  = r_q.filt[FI_MEL] ^ limit_logic_select_in;
  assign sd_on   = r_q.filt[FI_SD] ^ ~r_q.env1[ENV_SDL];
  assign org_on  = r_q.filt[FI_ORG] ^ ~r_q.env1[ENV_ORGL];
  assign sd_slow = r_q.prmd[PRMD_MSDE] & (sd_on | (r_q.env1[ENV_SDLT] & r_q.sd_latch));
  assign sd_stop = sd_slow & r_q.env1[ENV_SDM];

  // Period is rmg+1 units; active part is floor of half, shorter when odd
  assign period_w  = {1'b0, r_q.speed_multiplier_setting} + 1'b1;
  assign on_units  = period_w[SPD_W:1];
  assign phase_inc = r_q.phase + 1'b1;
  assign tick      = ({1'b0, r_q.unit_cnt} + 1'b1) >= {1'b0, r_q.cur_div};
  assign per_end   = tick && (r_q.phase == r_q.speed_multiplier_setting);
  assign act_end   = tick && (phase_inc == on_units);

  assign pmd       = r_q.env1[ENV_PMD_LSB +: 3];
  assign wr_cmd    = bus_in.wr && (bus_in.addr == OFS_CMD);
  assign cmd       = bus_in.wdata[7:0];
  assign start_cmd = wr_cmd && ((cmd == CMD_START_FL) || (cmd == CMD_START_FH) ||
                                (cmd == CMD_START_RAMP) || (cmd == CMD_START_RAMPUD));
  assign start_neg = r_q.prmd[PRMD_DIR];

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic finish;
    logic new_per;
    logic lvl;
    logic idle_lvl;
    finish   = 1'b0;
    new_per  = 1'b0;
    lvl      = 1'b0;
    idle_lvl = 1'b0;
    r_d      = r_q;
    r_d.done = 1'b0;

    // Input filters: a change must persist for the limit before it is taken
    for (int i = 0; i < N_FILT; i++) begin
      if (raw[i] == r_q.filt[i]) begin
        r_d.fcnt[i] = '0;
      end else if ({1'b0, r_q.fcnt[i]} + 1'b1 >= {1'b0, filt_lim}) begin
        r_d.filt[i] = raw[i];
        r_d.fcnt[i] = '0;
      end else begin
        r_d.fcnt[i] = r_q.fcnt[i] + 1'b1;
      end
    end

    // Register writes
    if (bus_in.wr) begin
      unique case (bus_in.addr)
        OFS_ENV1:   r_d.env1   = bus_in.wdata;
        OFS_PRMD:   r_d.prmd   = bus_in.wdata;
        OFS_RMG:    r_d.speed_multiplier_setting    = bus_in.wdata[SPD_W-1:0];
        OFS_FL:     r_d.fl_div = bus_in.wdata[SPD_W-1:0];
        OFS_FH:     r_d.fh_div = bus_in.wdata[SPD_W-1:0];
        OFS_PCOUNT: r_d.pcount = bus_in.wdata[CNT_W-1:0];
        OFS_CAUSE:  r_d.cause  = r_q.cause & ~bus_in.wdata;
        default:    r_d.cause  = r_d.cause;
      endcase
    end

    unique case (r_q.st)
      ST_IDLE: begin
        if (start_cmd) begin
          if (sd_on == 1'b0) begin
            r_d.sd_latch = 1'b0;
          end
          if (!start_neg && pel_on) begin
            r_d.cause[CAU_PEL] = 1'b1;
            r_d.done = 1'b1;
          end else if (start_neg && mel_on) begin
            r_d.cause[CAU_MEL] = 1'b1;
            r_d.done = 1'b1;
          end else if (sd_on && r_q.prmd[PRMD_MSDE] && r_q.env1[ENV_SDM]) begin
            // Only a live input refuses; a stale latch clears at this start
            r_d.cause[CAU_SD] = 1'b1;
            r_d.done = 1'b1;
          end else begin
            r_d.busy     = 1'b1;
            r_d.ramp     = (cmd == CMD_START_RAMP) || (cmd == CMD_START_RAMPUD);
            r_d.cur_div  = (cmd == CMD_START_FH) ? r_q.fh_div : r_q.fl_div;
            r_d.endless  = (r_q.pcount == '0);
            r_d.remain   = r_q.pcount;
            r_d.final_p  = (r_q.pcount == CNT_W'(1));
            r_d.imm_stop = 1'b0;
            r_d.dec_stop = 1'b0;
            r_d.unit_cnt = '0;
            r_d.phase    = '0;
            r_d.dir_neg  = start_neg;
            if ((pmd[2] == 1'b0) && (start_neg != r_q.dir_neg)) begin
              r_d.st       = ST_DIRWAIT;
              r_d.wait_cnt = r_q.env1[ENV_DTMF] ? WAIT_W'(DIR_WAIT_SHORT_CYC)
                                                : WAIT_W'(DIR_WAIT_LONG_CYC);
            end else begin
              r_d.st  = ST_RUN;
              new_per = 1'b1;
            end
          end
        end
      end

      ST_DIRWAIT: begin
        r_d.wait_cnt = r_q.wait_cnt - 1'b1;
        if (wr_cmd && (cmd == CMD_STOP_IMM || cmd == CMD_STOP_DEC)) begin
          finish = 1'b1;
        end else if (r_q.wait_cnt <= WAIT_W'(1)) begin
          r_d.st  = ST_RUN;
          new_per = 1'b1;
        end
      end

      ST_RUN: begin
        r_d.unit_cnt = tick ? '0 : r_q.unit_cnt + 1'b1;
        if (tick) begin
          r_d.phase = per_end ? '0 : phase_inc;
        end
        if (wr_cmd && (cmd == CMD_STOP_IMM)) begin
          r_d.imm_stop = 1'b1;
        end
        if (wr_cmd && (cmd == CMD_STOP_DEC)) begin
          r_d.dec_stop = r_q.ramp;
          r_d.imm_stop = r_q.imm_stop | ~r_q.ramp;
        end
        // Limit in the direction of travel
        if ((!r_q.dir_neg && pel_on) || (r_q.dir_neg && mel_on)) begin
          r_d.cause[CAU_PEL] = r_d.cause[CAU_PEL] | ~r_q.dir_neg;
          r_d.cause[CAU_MEL] = r_d.cause[CAU_MEL] | r_q.dir_neg;
          if (r_q.env1[ENV_ELM] && r_q.ramp) begin
            r_d.dec_stop = 1'b1;
          end else begin
            r_d.imm_stop = 1'b1;
          end
        end
        // Constant-speed run stops at once on a stop-type slow-down
        if (sd_stop && !r_q.ramp) begin
          r_d.imm_stop      = 1'b1;
          r_d.cause[CAU_SD] = 1'b1;
        end

        if (r_q.imm_stop && !r_q.act) begin
          finish = 1'b1;
        end else if (r_q.final_p && (r_q.prmd[PRMD_COMPLETION_TIMING_SELECT] ? act_end : per_end)) begin
          finish = 1'b1;
        end else if (per_end && r_q.ramp && (r_q.dec_stop || sd_stop) &&
                     (r_q.cur_div >= r_q.fl_div)) begin
          finish = 1'b1;
          if (sd_stop && !r_q.dec_stop) begin
            r_d.cause[CAU_SD] = 1'b1;
          end
        end else if (per_end) begin
          new_per = 1'b1;
          if (!r_q.endless) begin
            r_d.remain  = r_q.remain - 1'b1;
            r_d.final_p = (r_q.remain == CNT_W'(2));
          end
          // Ramp by one divisor step per period; slow-down aims at start speed
          if (r_q.ramp) begin
            if (r_q.dec_stop || sd_slow) begin
              if (r_q.cur_div < r_q.fl_div) begin
                r_d.cur_div = r_q.cur_div + 1'b1;
              end
            end else if (r_q.cur_div > r_q.fh_div) begin
              r_d.cur_div = r_q.cur_div - 1'b1;
            end else if (r_q.cur_div < r_q.fh_div) begin
              r_d.cur_div = r_q.cur_div + 1'b1;
            end
          end
        end
      end
    endcase

    if (finish) begin
      r_d.st   = ST_IDLE;
      r_d.busy = 1'b0;
      r_d.done = 1'b1;
    end
    if (new_per) begin
      r_d.quad = r_d.dir_neg ? r_q.quad - 1'b1 : r_q.quad + 1'b1;
    end
    r_d.act = (r_d.st == ST_RUN) && (r_d.phase < on_units);

    // Latch sets on the input while enabled and holds; clearing the enable clears it
    if (!r_d.env1[ENV_SDLT]) begin
      r_d.sd_latch = 1'b0;
    end else if (sd_on) begin
      r_d.sd_latch = 1'b1;
    end

    // Pin forms
    lvl      = r_d.act ~^ r_d.env1[ENV_PMD_LSB];
    idle_lvl = ~r_d.env1[ENV_PMD_LSB];
    unique case (r_d.env1[ENV_PMD_LSB +: 3])
      PMD_2P_NEG, PMD_2P_POS: begin
        r_d.out_pin = r_d.dir_neg ? idle_lvl : lvl;
        r_d.dir_pin = r_d.dir_neg ? lvl : idle_lvl;
      end
      PMD_QUAD: begin
        r_d.out_pin = r_d.quad[1];
        r_d.dir_pin = r_d.quad[1] ^ r_d.quad[0];
      end
      PMD_QUAD_SWAP: begin
        r_d.out_pin = r_d.quad[1] ^ r_d.quad[0];
        r_d.dir_pin = r_d.quad[1];
      end
      default: begin
        r_d.out_pin = lvl;
        r_d.dir_pin = ~r_d.dir_neg ^ r_d.env1[ENV_PMD_LSB + 1];
      end
    endcase

    // Read data stands only in the cycle after the strobe
    r_d.rdata = '0;
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        OFS_ENV1:   r_d.rdata = r_q.env1;
        OFS_PRMD:   r_d.rdata = r_q.prmd;
        OFS_RMG:    r_d.rdata = DATA_W'(r_q.speed_multiplier_setting);
        OFS_FL:     r_d.rdata = DATA_W'(r_q.fl_div);
        OFS_FH:     r_d.rdata = DATA_W'(r_q.fh_div);
        OFS_PCOUNT: r_d.rdata = DATA_W'(r_q.pcount);
        OFS_SUBST: begin
          r_d.rdata[SST_BUSY]    = r_q.busy;
          r_d.rdata[SST_PEL]     = pel_on;
          r_d.rdata[SST_MEL]     = mel_on;
          r_d.rdata[SST_ORG]     = org_on;
          r_d.rdata[SST_SDLATCH] = r_q.sd_latch;
        end
        OFS_EXTST: begin
          r_d.rdata[EXT_BUSY] = r_q.busy;
          r_d.rdata[EXT_SDIN] = sd_on;
        end
        OFS_CAUSE:  r_d.rdata = r_q.cause;
        default:    r_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      r_q <= STATE_RST;
    end else begin
      r_q <= r_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rdata_out                = r_q.rdata;
  assign pulse_output_pin_out     = r_q.out_pin;
  assign direction_output_pin_out = r_q.dir_pin;
  assign busy_out                 = r_q.busy;
  assign done_out                 = r_q.done;

endmodule

`default_nettype wire

// ---- hw/apls_pkg.sv ----
// Purpose: Shared constants and types of the axis pulse, limit and slow-down block
// Assumes: 200 MHz reference clock, byte addresses on the register port
// Notes:   Times are kept in ns and cycle counts are derived from them, except FILT_OFF_CYC, which is given in cycles

package apls_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } apls_bus_req_type;

  localparam logic [ADDR_W-1:0] OFS_ENV1    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PRMD    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RMG     = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FL      = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_FH      = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PCOUNT  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CMD     = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_SUBST   = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_EXTST   = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CAUSE   = 8'h24;

  localparam logic [DATA_W-1:0] ENV1_RST    = 32'h0000_0000;
  localparam logic [DATA_W-1:0] PRMD_RST    = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int ENV_PMD_LSB = 0;
  localparam int ENV_ELM     = 3;
  localparam int ENV_SDM     = 4;
  localparam int ENV_SDLT    = 5;
  localparam int ENV_SDL     = 6;
  localparam int ENV_ORGL    = 7;
  localparam int ENV_FTM_LSB = 20;
  localparam int ENV_FLTR    = 26;
  localparam int ENV_DTMF    = 28;

  localparam int PRMD_DIR    = 3;
  localparam int PRMD_MSDE   = 8;
  localparam int PRMD_COMPLETION_TIMING_SELECT   = 12;

  localparam int SST_BUSY    = 0;
  localparam int SST_PEL     = 12;
  localparam int SST_MEL     = 13;
  localparam int SST_ORG     = 14;
  localparam int SST_SDLATCH = 15;
  localparam int EXT_BUSY    = 0;
  localparam int EXT_SDIN    = 14;

  localparam int CAU_PEL     = 0;
  localparam int CAU_MEL     = 1;
  localparam int CAU_SD      = 5;

  ////////////////////////////////////////////////////////////////////////////////
  // Commands and modes
  localparam logic [7:0] CMD_STOP_IMM    = 8'h49;
  localparam logic [7:0] CMD_STOP_DEC    = 8'h4a;
  localparam logic [7:0] CMD_START_FL    = 8'h50;
  localparam logic [7:0] CMD_START_FH    = 8'h51;
  localparam logic [7:0] CMD_START_RAMP  = 8'h52;
  localparam logic [7:0] CMD_START_RAMPUD = 8'h53;

  localparam logic [2:0] PMD_2P_NEG      = 3'h4;
  localparam logic [2:0] PMD_QUAD        = 3'h5;
  localparam logic [2:0] PMD_QUAD_SWAP   = 3'h6;
  localparam logic [2:0] PMD_2P_POS      = 3'h7;

  typedef enum logic [1:0] {ST_IDLE, ST_DIRWAIT, ST_RUN} apls_state_type;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ           = 200;
  localparam int DIR_WAIT_LONG_NS  = 200000;
  localparam int DIR_WAIT_SHORT_NS = 500;
  localparam int FILT_OFF_CYC      = 2;
  localparam int FILT_3U2_NS       = 3200;
  localparam int FILT_25U_NS       = 25000;
  localparam int FILT_200U_NS      = 200000;
  localparam int FILT_1M6_NS       = 1600000;

  // Least times: round up to whole cycles
  localparam int DIR_WAIT_LONG_CYC_DEF  = (DIR_WAIT_LONG_NS * CLK_MHZ + 999) / 1000;
  localparam int DIR_WAIT_SHORT_CYC     = (DIR_WAIT_SHORT_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_3U2_CYC           = (FILT_3U2_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_25U_CYC_DEF       = (FILT_25U_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_200U_CYC_DEF      = (FILT_200U_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_1M6_CYC_DEF       = (FILT_1M6_NS * CLK_MHZ + 999) / 1000;

  localparam int FCNT_W = 20;
  localparam int WAIT_W = 20;

  localparam int N_FILT = 4;
  localparam int FI_PEL = 0;
  localparam int FI_MEL = 1;
  localparam int FI_SD  = 2;
  localparam int FI_ORG = 3;

endpackage

// ---- test/apls_axis_chk.sv ----
// Purpose: Port assertions for the axis block
// Assumes: Input timing checks apply with the noise filter off
// Notes:   Stop bound suits short test speeds only
`timescale 1ns/1ps
`default_nettype none
module apls_axis_chk
  import apls_pkg::*;
(
  // Clock, reset, register port
  input wire logic                       sys_clk_in,
  input wire logic                       rstn_in,
  input wire apls_pkg::apls_bus_req_type bus_in,
  input wire logic [31:0]                rdata_out,
  // Pins and status
  input wire logic pulse_output_pin_out,
  input wire logic direction_output_pin_out,
  input wire logic positive_limit_input_in,
  input wire logic negative_limit_input_in,
  input wire logic slowdown_switch_input_in,
  input wire logic origin_switch_input_in,
  input wire logic limit_logic_select_in,
  input wire logic busy_out,
  input wire logic done_out
);
  logic [31:0] env_q;
  logic [31:0] prmd_q;
  logic        pel_on;
  logic        mel_on;
  logic        sd_on;
  logic        start_wr;
  assign pel_on = (positive_limit_input_in ^ limit_logic_select_in) && !env_q[ENV_FLTR];
  assign mel_on = (negative_limit_input_in ^ limit_logic_select_in) && !env_q[ENV_FLTR];
  assign sd_on = slowdown_switch_input_in == env_q[ENV_SDL];
  assign start_wr = bus_in.wr && bus_in.addr == OFS_CMD && bus_in.wdata[7:2] == 6'h14;
  // Shadow of the mode registers, written only by the bus
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      env_q <= '0;
      prmd_q <= '0;
    end else if (bus_in.wr) begin
      if (bus_in.addr == OFS_ENV1) env_q <= bus_in.wdata;
      if (bus_in.addr == OFS_PRMD) prmd_q <= bus_in.wdata;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence pel_held; pel_on [*4]; endsequence
  sequence mel_held; mel_on [*4]; endsequence
  sequence sd_steady; (!env_q[ENV_FLTR] && $stable(slowdown_switch_input_in)) [*4]; endsequence
  AST_DONE_ONE: assert property (done_out |=> !done_out)
    else $error("done held too long");
  AST_BUSY_DONE: assert property ($fell(busy_out) |-> done_out)
    else $error("busy ended without done");
  AST_RD_IDLE: assert property (!bus_in.rd |=> rdata_out == '0)
    else $error("read data outside read slot");
  AST_REFUSE: assert property ((pel_held ##0 (start_wr && !busy_out && !prmd_q[PRMD_DIR]))
    or (mel_held ##0 (start_wr && !busy_out && prmd_q[PRMD_DIR])) |=> done_out && !busy_out)
    else $error("start toward active limit taken");
  AST_SST_PEL: assert property (pel_held ##0 (bus_in.rd && bus_in.addr == OFS_SUBST)
    |=> rdata_out[SST_PEL])
    else $error("positive limit status low");
  AST_SST_MEL: assert property (mel_held ##0 (bus_in.rd && bus_in.addr == OFS_SUBST)
    |=> rdata_out[SST_MEL])
    else $error("negative limit status low");
  AST_EXT_SD: assert property (sd_steady ##0 (bus_in.rd && bus_in.addr == OFS_EXTST)
    |=> rdata_out[EXT_SDIN] == $past(sd_on))
    else $error("slow-down input status wrong");
  AST_DIR_HOLD: assert property (busy_out && $past(busy_out) && !env_q[ENV_PMD_LSB+2]
    |-> $stable(direction_output_pin_out))
    else $error("direction moved in a run");
  AST_PEL_STOP: assert property (pel_held ##0 (busy_out && !prmd_q[PRMD_DIR] && !env_q[ENV_ELM])
    |-> ##[0:1000] !busy_out)
    else $error("no stop at positive limit");
endmodule
bind apls_axis apls_axis_chk u_chk (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
  .bus_in(bus_in), .rdata_out(rdata_out), .pulse_output_pin_out(pulse_output_pin_out),
  .direction_output_pin_out(direction_output_pin_out),
  .positive_limit_input_in(positive_limit_input_in),
  .negative_limit_input_in(negative_limit_input_in),
  .slowdown_switch_input_in(slowdown_switch_input_in),
  .origin_switch_input_in(origin_switch_input_in),
  .limit_logic_select_in(limit_logic_select_in), .busy_out(busy_out), .done_out(done_out));
`default_nettype wire

// ---- test/apls_drv_model.sv ----
// Purpose: Motor driver and end switches on a slider
// Assumes: Pulse plus direction, pulse active low, direction high positive
// Notes:   Position moves on each falling pulse edge
`timescale 1ns/1ps
`default_nettype none
module apls_drv_model (
  // Clock and driver pins
  input  wire logic               sys_clk_in,
  input  wire logic               pulse_in,
  input  wire logic               dir_in,
  // Switch placement
  input  wire logic               sel_in,
  input  wire logic signed [31:0] pel_at_in,
  input  wire logic signed [31:0] mel_at_in,
  output var  logic signed [31:0] pos_out,
  output logic                    pel_out,
  output logic                    mel_out
);
  logic pulse_d;
  initial begin
    pos_out = '0;
    pulse_d = 1'b1;
  end
  always @(posedge sys_clk_in) begin
    pulse_d <= pulse_in;
    if (pulse_d && !pulse_in) pos_out <= dir_in ? pos_out + 1 : pos_out - 1;
  end
  // Switch levels follow the polarity pin
  assign pel_out = (pos_out >= pel_at_in) ^ sel_in;
  assign mel_out = (pos_out <= mel_at_in) ^ sel_in;
endmodule
`default_nettype wire

// ---- test/tb_apls_axis.sv ----
// Purpose: Self-checking bench of the axis block
// Assumes: Short wait and filter parameters
// Notes:   Random speeds and counts from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module tb_apls_axis;
  import apls_pkg::*;
  logic                 clk = 1'b0, rstn = 1'b0, sel = 1'b0, sd = 1'b0;
  apls_bus_req_type     bus = '0;
  logic [31:0]          rdata, rv, e, seed = 32'h104e631b;
  logic                 pulse, dir, busy, done, pel, mel;
  logic signed [31:0]   pos, p0, pel_at = 32'h0fff_ffff, mel_at = 32'hf000_0000;
  int                   n_mismatch = 0, num_checks = 0, cyc = 0, r, n, k, w;
  apls_axis #(.DIR_WAIT_LONG_CYC(50), .FILT_25U_CYC(20), .FILT_200U_CYC(30),
    .FILT_1M6_CYC(40)) DUT (.sys_clk_in(clk), .rstn_in(rstn), .bus_in(bus),
    .rdata_out(rdata), .pulse_output_pin_out(pulse), .direction_output_pin_out(dir),
    .positive_limit_input_in(pel), .negative_limit_input_in(mel),
    .slowdown_switch_input_in(sd), .origin_switch_input_in(sd),
    .limit_logic_select_in(sel), .busy_out(busy), .done_out(done));
  apls_drv_model u_drv (.sys_clk_in(clk), .pulse_in(pulse), .dir_in(dir), .sel_in(sel),
    .pel_at_in(pel_at), .mel_at_in(mel_at), .pos_out(pos), .pel_out(pel), .mel_out(mel));
  initial begin
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 rv = rdata;
  endtask
  // A refused start answers at once; a hang runs into the cycle ceiling
  task automatic wait_done(output int c);
    c = 0;
    #1;
    while (done !== 1'b1) begin
      @(posedge clk);
      #1 c++;
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(OFS_ENV1); chk(rv, ENV1_RST);
    rd(8'hfc); chk(rv, 32'h0);
    rd(OFS_EXTST); chk(rv, 32'h4000);
    for (int i = 0; i < 4; i++) begin
      e = xorshift();
      bw(i[0] ? OFS_PRMD : OFS_ENV1, e);
      rd(i[0] ? OFS_PRMD : OFS_ENV1); chk(rv, e);
    end
    bw(OFS_ENV1, 32'h0); bw(OFS_PRMD, 32'h0); bw(OFS_FL, 32'h1);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      r = xorshift() % 6 + 1; n = xorshift() % 4 + 1;
      bw(OFS_RMG, r); bw(OFS_PCOUNT, n); bw(OFS_PRMD, i[0] << PRMD_COMPLETION_TIMING_SELECT);
      p0 = pos; bw(OFS_CMD, CMD_START_FL); wait_done(k);
      chk(k, i[0] ? (n - 1) * (r + 1) + (r + 1) / 2 : n * (r + 1));
      chk(pos - p0, n);
    end
    $display("test pulses done");
    bw(OFS_RMG, 1); bw(OFS_PCOUNT, 1);
    for (int i = 0; i < 2; i++) begin
      w = i ? 50 : 100;
      bw(OFS_ENV1, i ? 32'h0 : 32'h1 << ENV_DTMF); bw(OFS_PRMD, i ? 0 : 1 << PRMD_DIR);
      p0 = pos; bw(OFS_CMD, CMD_START_FH); repeat (w - 2) @(posedge clk);
      #1 chk(pos, p0);
      chk(dir, i);
      wait_done(k); chk(k <= 8, 1);
    end
    $display("test direction wait done");
    bw(OFS_PCOUNT, 0);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      sel <= i[0];
      pel_at <= pos + 3;
      mel_at <= pos - 3;
      bw(OFS_PRMD, i << PRMD_DIR); bw(OFS_CMD, CMD_START_FL); wait_done(k);
      rd(OFS_CAUSE); chk(rv, 1 << i);
      rd(OFS_SUBST); chk((rv >> 12) & 32'h3, 1 << i);
      bw(OFS_CAUSE, 32'hff); p0 = pos; bw(OFS_CMD, CMD_START_RAMPUD); wait_done(k);
      chk(pos, p0);
      chk(k, 0);
      rd(OFS_CAUSE); chk(rv, 1 << i);
      bw(OFS_CAUSE, 32'hff);
    end
    $display("test limits done");
    bw(OFS_PRMD, 1 << PRMD_MSDE); bw(OFS_ENV1, 32'h40); bw(OFS_ENV1, 32'h70);
    for (int i = 1; i < 3; i++) begin
      @(posedge clk);
      sd <= 1'b1;
      repeat (i) @(posedge clk);
      sd <= 1'b0;
      rd(OFS_SUBST); chk(rv[15], i - 1);
    end
    rd(OFS_EXTST); chk(rv[14], 0);
    // Input held on through the start: refused, latch stays set
    @(posedge clk);
    sd <= 1'b1;
    repeat (2) @(posedge clk);
    p0 = pos; bw(OFS_CMD, CMD_START_RAMP); wait_done(k); chk(pos, p0);
    chk(k, 0);
    rd(OFS_CAUSE); chk(rv, 32'h20);
    bw(OFS_ENV1, 32'h50); rd(OFS_SUBST); chk(rv[15:14], 0);
    $display("test slow-down done");
    print_verdict();
  end
endmodule
`default_nettype wire
